// ---- rtl/spr_pkg.sv ----
// package of register map, field layout and codes for the receive slot router
package spr_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_CH6_ROUTE  = 8'h2d;      // secondary_rx_channel6_route
  localparam logic [7:0] IDX_CH7_ROUTE  = 8'h2e;      // secondary_rx_channel7_route
  localparam logic [7:0] IDX_CH8_ROUTE  = 8'h2f;      // secondary_rx_channel8_route
  localparam logic [7:0] IDX_LINK_STAT  = 8'h30;      // read-only link position
  localparam int         ADDR_W         = 10;         // avalon byte address width
  localparam int         NUM_CH         = 3;          // channels 6, 7, 8

  // ==========================================================================
  // field layout of a route register
  localparam int         DEST_MSB       = 6;          // rx_chN_destination msb
  localparam int         DEST_LSB       = 5;          // rx_chN_destination lsb
  localparam int         SLOT_MSB       = 4;          // rx_chN_slot_select msb
  localparam int         SLOT_LSB       = 0;          // rx_chN_slot_select lsb
  localparam int         CFG_W          = 7;          // stored bits, bit 7 reserved

  // reset values of the route registers
  localparam logic [7:0] RST_CH6_ROUTE  = 8'h05;
  localparam logic [7:0] RST_CH7_ROUTE  = 8'h06;
  localparam logic [7:0] RST_CH8_ROUTE  = 8'h07;

  // destination codes
  localparam logic [1:0] DEST_OFF       = 2'h0;       // channel disabled
  localparam logic [1:0] DEST_PLAY      = 2'h1;       // playback channel
  localparam logic [1:0] DEST_LOOP      = 2'h2;       // record channel loopback
  localparam logic [1:0] DEST_CHAIN     = 2'h3;       // chained_device_link data

  // slot numbering in left/right formats
  localparam logic [4:0] HALF_SLOTS     = 5'h10;      // slots per half frame

  // avalon response codes
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_DECERR    = 2'h3;

  // bus answer states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,                                 // waiting for a request
    BUS_ACK  = 2'b10                                  // answering, waitrequest low
  } spr_bus_e;

endpackage

// ---- rtl/spr_rx_slot_router.sv ----
// receive slot router for channels 6..8 of the secondary_audio_port
// ============================================================================
// Summary of operation
// - ch6 destination picks off/play6/loop2/chain1
// - ch7 destination picks off/play7/loop3/chain2
// - ch8 destination picks off/play8/loop4/chain3
// - slot 0..15 is tdm or left slot
// - slot 16..31 is tdm or right slot
// - reset reads 0x05, 0x06, 0x07, disabled
`timescale 1ns/1ps

module spr_rx_slot_router
  import spr_pkg::*;
#(
  parameter int SLOT_BITS = 32                        // bits per slot
) (
  input  wire logic                          clk_sys,
  input  wire logic                          sys_rst,
  input  wire logic [spr_pkg::ADDR_W-1:0]    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [31:0]                   avs_readdata,
  output logic      [1:0]                    avs_response,
  output logic                               avs_waitrequest,
  input  wire logic                          lr_format,
  input  wire logic                          i2s_format,
  input  wire logic                          port_bclk,
  input  wire logic                          port_fsync,
  input  wire logic                          port_din,
  output logic      [spr_pkg::NUM_CH-1:0][SLOT_BITS-1:0] rx_word,
  output logic      [spr_pkg::NUM_CH-1:0]    playback_valid,
  output logic      [spr_pkg::NUM_CH-1:0]    loopback_valid,
  output logic      [spr_pkg::NUM_CH-1:0]    chained_valid
);
  import spr_pkg::*;

  localparam int BC_W = $clog2(SLOT_BITS);            // bit counter width
  localparam logic [BC_W-1:0] LAST_BIT = BC_W'(SLOT_BITS - 1);

  // refuse slot widths the counters cannot serve
  if (SLOT_BITS < 2 || SLOT_BITS > 32) begin : g_chk
    $error("SLOT_BITS must lie in 2..32");
  end

  // ==========================================================================
  // helpers
  // does a route config claim this frame slot
  function automatic logic chan_hit(input logic [CFG_W-1:0] cfg,
                                    input logic [4:0]       slot_idx);
    chan_hit = (cfg[DEST_MSB:DEST_LSB] != DEST_OFF) && (cfg[SLOT_MSB:SLOT_LSB] == slot_idx);
  endfunction

  // reset value of one channel's route
  function automatic logic [CFG_W-1:0] rst_cfg(input int ch);
    unique case (ch)
      0:       rst_cfg = RST_CH6_ROUTE[CFG_W-1:0];
      1:       rst_cfg = RST_CH7_ROUTE[CFG_W-1:0];
      default: rst_cfg = RST_CH8_ROUTE[CFG_W-1:0];
    endcase
  endfunction

  // ==========================================================================
  // avalon slave and route registers
  spr_bus_e                    bus_q, bus_d;          // answer state
  logic [NUM_CH-1:0][CFG_W-1:0] cfg_q, cfg_d;         // route registers
  logic [31:0]                 rdata_q, rdata_d;      // read data
  logic [1:0]                  resp_q, resp_d;        // response code
  logic [7:0]                  idx;                   // register index
  logic                        aligned;               // address on word boundary
  logic [4:0]                  eff_slot_q, eff_slot_d; // slot position for status

  assign idx     = avs_address[9:2];
  assign aligned = avs_address[1:0] == 2'h0;

  // waitrequest low in the answer cycle and whenever no request is pending
  assign avs_waitrequest = (avs_read | avs_write) & (bus_q != BUS_ACK);
  assign avs_readdata    = rdata_q;
  assign avs_response    = resp_q;

  // next bus state, read mux, register writes
  always_comb begin
    bus_d   = bus_q;
    cfg_d   = cfg_q;
    rdata_d = rdata_q;
    resp_d  = resp_q;
    unique case (bus_q)
      BUS_IDLE: begin
        // load answer one cycle after the request rises
        if (avs_read | avs_write) begin
          bus_d   = BUS_ACK;
          rdata_d = 32'h0;
          resp_d  = RESP_OKAY;
          if (aligned && idx >= IDX_CH6_ROUTE && idx <= IDX_CH8_ROUTE) begin
            // reserved bit 7 reads zero, writes ignored
            rdata_d = {25'h0, cfg_q[idx - IDX_CH6_ROUTE]};
          end else if (aligned && idx == IDX_LINK_STAT) begin
            rdata_d = {27'h0, eff_slot_q};
          end else begin
            resp_d = RESP_DECERR;
          end
        end
      end
      BUS_ACK: begin
        // write takes effect at the edge that sees waitrequest low
        bus_d = BUS_IDLE;
        if (avs_write && avs_byteenable[0] && aligned
            && idx >= IDX_CH6_ROUTE && idx <= IDX_CH8_ROUTE) begin
          cfg_d[idx - IDX_CH6_ROUTE] = avs_writedata[CFG_W-1:0];
        end
      end
    endcase
  end

  // bus registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bus_q   <= BUS_IDLE;
      rdata_q <= 32'h0;
      resp_q  <= RESP_OKAY;
      for (int c = 0; c < NUM_CH; c++) begin
        cfg_q[c] <= rst_cfg(c);
      end
    end else begin
      bus_q   <= bus_d;
      cfg_q   <= cfg_d;
      rdata_q <= rdata_d;
      resp_q  <= resp_d;
    end
  end

  // ==========================================================================
  // link input synchronisers
  logic [2:0] sync1_q, sync2_q;                       // bclk, fsync, din
  logic       bclk_prev_q, fs_prev_q;                 // previous sampled levels

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q     <= 3'h0;
      sync2_q     <= 3'h0;
      bclk_prev_q <= 1'b0;
    end else begin
      sync1_q     <= {port_bclk, port_fsync, port_din};
      sync2_q     <= sync1_q;
      bclk_prev_q <= sync2_q[2];
    end
  end

  logic bclk_rise;                                    // sampled bit-clock rising edge
  logic fs_now, din_now;                              // synchronised levels
  assign bclk_rise = sync2_q[2] & ~bclk_prev_q;
  assign fs_now    = sync2_q[1];
  assign din_now   = sync2_q[0];

  // ==========================================================================
  // frame position and slot capture
  logic [BC_W-1:0]      bit_q, bit_d;                 // bit within slot
  logic [4:0]           slot_q, slot_d;               // slot within frame/half
  logic                 right_q, right_d;             // right half in lr formats
  logic [SLOT_BITS-1:0] shift_q, shift_d;             // incoming bits
  logic                 fs_prev_d;
  logic [NUM_CH-1:0][SLOT_BITS-1:0] word_q, word_d;
  logic [NUM_CH-1:0]    play_q, play_d, loop_q, loop_d, chain_q, chain_d;

  always_comb begin
    logic            start;
    logic [BC_W-1:0] b;
    logic [4:0]      s;
    logic            r;
    logic [4:0]      eff;
    logic [SLOT_BITS-1:0] w;
    start     = 1'b0;
    b         = bit_q;
    s         = slot_q;
    r         = right_q;
    eff       = 5'h0;
    w         = {shift_q[SLOT_BITS-2:0], din_now};
    bit_d     = bit_q;
    slot_d    = slot_q;
    right_d   = right_q;
    shift_d   = shift_q;
    fs_prev_d = fs_prev_q;
    word_d    = word_q;
    eff_slot_d = eff_slot_q;
    play_d    = '0;
    loop_d    = '0;
    chain_d   = '0;
    if (bclk_rise) begin
      fs_prev_d = fs_now;
      // tdm starts on fsync rise; lr formats restart on either edge
      start = lr_format ? (fs_now != fs_prev_q) : (fs_now & ~fs_prev_q);
      if (start) begin
        b = '0;
        s = 5'h0;
        r = lr_format & (fs_now == i2s_format);
      end
      shift_d = w;
      // slot index seen by the slot fields
      eff = lr_format ? (r ? HALF_SLOTS + {1'b0, s[3:0]} : {1'b0, s[3:0]})
                      : s;
      eff_slot_d = eff;
      if (b == LAST_BIT) begin
        for (int c = 0; c < NUM_CH; c++) begin
          // lr halves hold 16 slots at most
          if (chan_hit(cfg_q[c], eff) && !(lr_format && s[4])) begin
            word_d[c]  = w;
            play_d[c]  = cfg_q[c][DEST_MSB:DEST_LSB] == DEST_PLAY;
            loop_d[c]  = cfg_q[c][DEST_MSB:DEST_LSB] == DEST_LOOP;
            chain_d[c] = cfg_q[c][DEST_MSB:DEST_LSB] == DEST_CHAIN;
          end
        end
        bit_d  = '0;
        slot_d = s + 5'h1;
      end else begin
        bit_d  = b + BC_W'(1);
        slot_d = s;
      end
      right_d = r;
    end
  end

  // link registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bit_q      <= '0;
      slot_q     <= 5'h0;
      right_q    <= 1'b0;
      shift_q    <= '0;
      fs_prev_q  <= 1'b0;
      word_q     <= '0;
      eff_slot_q <= 5'h0;
      play_q     <= '0;
      loop_q     <= '0;
      chain_q    <= '0;
    end else begin
      bit_q      <= bit_d;
      slot_q     <= slot_d;
      right_q    <= right_d;
      shift_q    <= shift_d;
      fs_prev_q  <= fs_prev_d;
      word_q     <= word_d;
      eff_slot_q <= eff_slot_d;
      play_q     <= play_d;
      loop_q     <= loop_d;
      chain_q    <= chain_d;
    end
  end

  assign rx_word        = word_q;
  assign playback_valid = play_q;
  assign loopback_valid = loop_q;
  assign chained_valid  = chain_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_last_bit(int c);
    bclk_rise && bit_q == LAST_BIT && cfg_q[c][DEST_MSB:DEST_LSB] != DEST_OFF;
  endsequence

  // disabled channel 6 never delivers
  disabled_no_out_a: assert property (
    cfg_q[0][DEST_MSB:DEST_LSB] == DEST_OFF |=> !(play_q[0] | loop_q[0] | chain_q[0]))
    else $error("disabled channel 6 delivered a word");

  ch6_dest_sel_a: assert property (
    play_q[0] |-> $past(cfg_q[0][DEST_MSB:DEST_LSB]) == DEST_PLAY)
    else $error("channel 6 playback pulse with wrong destination");

  ch7_dest_sel_a: assert property (
    loop_q[1] |-> $past(cfg_q[1][DEST_MSB:DEST_LSB]) == DEST_LOOP)
    else $error("channel 7 loopback pulse with wrong destination");

  ch8_dest_sel_a: assert property (
    chain_q[2] |-> $past(cfg_q[2][DEST_MSB:DEST_LSB]) == DEST_CHAIN)
    else $error("channel 8 chain pulse with wrong destination");

  tdm_slot_map_a: assert property (
    s_last_bit(0) && !lr_format && slot_q == cfg_q[0][SLOT_MSB:SLOT_LSB]
    |=> (play_q[0] | loop_q[0] | chain_q[0]) && rx_word[0] == $past(shift_d))
    else $error("tdm slot word not delivered for channel 6");

  lr_right_map_a: assert property (
    (play_q[1] | loop_q[1] | chain_q[1]) && $past(lr_format)
    |-> $past(right_q) == $past(cfg_q[1][SLOT_MSB]))
    else $error("left/right half mismatch for channel 7");

  reset_route_a: assert property (
    $fell(sys_rst) |-> cfg_q[0] == RST_CH6_ROUTE[CFG_W-1:0]
      && cfg_q[1] == RST_CH7_ROUTE[CFG_W-1:0] && cfg_q[2] == RST_CH8_ROUTE[CFG_W-1:0])
    else $error("route registers not at reset values");

  reserved_zero_a: assert property (
    bus_q == BUS_ACK && avs_read |-> avs_readdata[31:7] == 25'h0)
    else $error("reserved read bits not zero");

  bus_answer_a: assert property (
    (avs_read | avs_write) && bus_q == BUS_IDLE |=> !avs_waitrequest || !(avs_read | avs_write))
    else $error("bus answer not one cycle after request");

endmodule

// ---- sim/spr_host_model.sv ----
// host audio processor model driving the secondary_audio_port receive pins
`timescale 1ns/1ps

module spr_host_model #(
  parameter int SLOT_BITS = 8,                    // bits per slot
  parameter int HALF_NS   = 160                   // half period of the 320 ns bit clock
) (
  output logic                            port_bclk,
  output logic                            port_fsync,
  output logic                            port_din,
  input  wire logic                       lr_mode,
  input  wire logic                       i2s_mode,
  input  wire logic [31:0][SLOT_BITS-1:0] words
);
  // ==========================================================================
  // idle levels: bit clock stands still outside frames
  initial begin
    port_bclk  = 1'b0;
    port_fsync = 1'b0;
    port_din   = 1'b0;
  end

  // ==========================================================================
  // one frame: 32 tdm slots, or two halves of 16 slots in lr formats
  task automatic send_frame();
    logic left_lvl;
    left_lvl   = !i2s_mode;                       // i2s left half while sync is low
    port_fsync = lr_mode ? !left_lvl : 1'b0;      // park so the frame opens on an edge
    #(HALF_NS);
    port_bclk  = 1'b1;                            // lead-in bit latches the parked sync level
    #(HALF_NS);
    port_bclk  = 1'b0;
    for (int g = 0; g < 32; g++) begin            // slot g answers field value g
      for (int b = SLOT_BITS-1; b >= 0; b--) begin
        port_din   = words[g][b];                 // msb first
        port_fsync = lr_mode ? ((g < 16) ? left_lvl : !left_lvl) : (g == 0 && b == SLOT_BITS-1);
        #(HALF_NS);
        port_bclk = 1'b1;
        #(HALF_NS);
        port_bclk = 1'b0;
      end
    end
    port_din = !port_din;                         // released data shows no stale bit
    #(4*HALF_NS);
  endtask
endmodule

// ---- sim/spr_rx_slot_router_tb_top.sv ----
// testbench of the receive slot router: register access and slot routing per format
`timescale 1ns/1ps

module spr_rx_slot_router_tb_top;
  import spr_pkg::*;
  localparam int SB = 8;                          // shortened slot width
  logic                      clk_sys = 1'b0;
  logic                      sys_rst = 1'b1;
  logic [ADDR_W-1:0]         avs_address = '0;
  logic                      avs_read = 1'b0;
  logic                      avs_write = 1'b0;
  logic [31:0]               avs_writedata = '0;
  logic [3:0]                avs_byteenable = 4'hf;
  logic [31:0]               avs_readdata, rd;
  logic [1:0]                avs_response, rs;
  logic                      avs_waitrequest;
  logic                      lr_format = 1'b0;
  logic                      i2s_format = 1'b0;
  logic                      port_bclk, port_fsync, port_din;
  logic [NUM_CH-1:0][SB-1:0] rx_word;
  logic [NUM_CH-1:0]         playback_valid, loopback_valid, chained_valid;
  logic [31:0][SB-1:0]       words = '0;
  logic [SB-1:0]             seen [NUM_CH];       // last word delivered per channel
  logic [31:0]               shadow [NUM_CH];     // expected register contents
  logic [1:0]                dst [NUM_CH];
  logic [4:0]                slot [NUM_CH];
  int                        cnt [NUM_CH][4];     // pulses per channel and destination
  int                        errors = 0;
  int                        checks = 0;

  always #20 clk_sys = ~clk_sys;

  spr_rx_slot_router #(.SLOT_BITS(SB)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_response(avs_response),
    .avs_waitrequest(avs_waitrequest), .lr_format(lr_format), .i2s_format(i2s_format),
    .port_bclk(port_bclk), .port_fsync(port_fsync), .port_din(port_din), .rx_word(rx_word),
    .playback_valid(playback_valid), .loopback_valid(loopback_valid),
    .chained_valid(chained_valid));

  spr_host_model #(.SLOT_BITS(SB)) u_host (.port_bclk(port_bclk), .port_fsync(port_fsync),
    .port_din(port_din), .lr_mode(lr_format), .i2s_mode(i2s_format), .words(words));

  // ==========================================================================
  // pulse monitor, sampled mid-cycle where outputs are settled
  always @(negedge clk_sys) begin
    for (int c = 0; c < NUM_CH; c++) begin
      logic [3:1] v;
      v = {chained_valid[c], loopback_valid[c], playback_valid[c]};
      for (int k = 1; k < 4; k++) begin
        if (v[k] === 1'b1) begin
          cnt[c][k]++;
          seen[c] = rx_word[c];
        end
      end
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // avalon master: hold the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] wd,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= wd;
    avs_byteenable <= be;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 20) begin
        errors++;
        $display("MISMATCH waitrequest expected 0 seen 1");
        tally_and_finish();
      end
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rs = avs_response;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  function automatic logic [9:0] ra(int c);
    return 10'((int'(IDX_CH6_ROUTE) + c) * 4);
  endfunction

  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(32'h68a4));
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      bus(1'b0, ra(c), 32'h0, 4'hf);
      check("reset route", 32'(5 + c), rd);
      shadow[c] = 32'(5 + c);
    end
    $display("test reset values done");
    for (int i = 0; i < 9; i++) begin
      logic [31:0] v;
      v = $urandom & 32'hffff_ff7f;               // reserved bit 7 written as zero
      bus(1'b1, ra(i % 3), v, (i == 8) ? 4'he : 4'hf);
      if (i != 8) shadow[i % 3] = v & 32'h7f;
      bus(1'b0, ra(i % 3), 32'h0, 4'hf);
      check("route readback", shadow[i % 3], rd);
      check("route response", 32'(RESP_OKAY), 32'(rs));
    end
    bus(1'b0, 10'h100, 32'h0, 4'hf);
    check("unmapped response", 32'(RESP_DECERR), 32'(rs));
    check("unmapped data", 32'h0, rd);
    bus(1'b0, ra(0) + 10'h1, 32'h0, 4'hf);
    check("misaligned response", 32'(RESP_DECERR), 32'(rs));
    $display("test register access done");
    for (int m = 0; m < 3; m++) begin
      for (int d = 0; d < 4; d++) begin
        @(posedge clk_sys);
        lr_format  <= (m != 0);
        i2s_format <= (m == 1);
        for (int c = 0; c < NUM_CH; c++) begin
          dst[c]  = 2'((d + c) % 4);
          slot[c] = (d == 0) ? 5'(c * 15 + 32'(c == 2)) : 5'($urandom);
          bus(1'b1, ra(c), {25'h0, dst[c], slot[c]}, 4'hf);
          for (int k = 0; k < 4; k++) cnt[c][k] = 0;
        end
        for (int g = 0; g < 32; g++) words[g] = SB'($urandom);
        u_host.send_frame();
        bus(1'b0, 10'(int'(IDX_LINK_STAT) * 4), 32'h0, 4'hf);
        check("link slot", 32'h1f, rd);
        for (int c = 0; c < NUM_CH; c++) begin
          for (int k = 1; k < 4; k++) begin
            check("pulse count", 32'(dst[c] == k), 32'(cnt[c][k]));
          end
          if (dst[c] != 2'h0) check("slot word", 32'(words[slot[c]]), 32'(seen[c]));
        end
        $display("test routing mode %0d step %0d done", m, d);
      end
    end
    tally_and_finish();
  end
endmodule
